// file: core/cip_pace_counter.sv
// Purpose: loadable down-counter that stops at zero
// Assumes: load wins over counting in the same cycle
// Notes: counts once per clock, no prescaler
`timescale 1ns/1ns
module cip_pace_counter #(
   parameter int W = 18
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // load control
   input wire logic load_in,
   input wire logic [W-1:0] load_value_in,
   // state
   output logic [W-1:0] count_out,
   output logic zero_out
);
   logic [W-1:0] count_r;
   logic [W-1:0] count_nxt;

   // next count: load, else decrement down to zero
   always_comb begin
      count_nxt = count_r;
      if (load_in) begin
         count_nxt = load_value_in;
      end else if (count_r != '0) begin
         count_nxt = count_r - W'(1);
      end
   end

   // register; cleared on reset so no pacing by default
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         count_r <= '0;
      end else begin
         count_r <= count_nxt;
      end
   end

   assign count_out = count_r;
   assign zero_out = (count_r == '0);
endmodule

// file: core/cip_pkg.sv
// Purpose: shared constants of the combined interrupt pacer
// Assumes: one peripheral clock, 32-bit register port, byte offsets
// Notes: offsets are byte addresses of aligned 32-bit words
package cip_pkg;
   // register port shape
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   // number of level interrupt sources merged into one line
   localparam int SRC_W = 20;
   // register offsets
   localparam logic [7:0] CTL_OFS = 8'h04;
   localparam logic [7:0] CNT_OFS = 8'h08;
   localparam logic [7:0] TIMER_OFS = 8'h0C;
   localparam logic [7:0] STAT_OFS = 8'h10;
   localparam logic [7:0] MASK_OFS = 8'h14;
   // field layout
   localparam int ENABLE_BIT = 0;
   localparam int CNT_W = 18;
   localparam int CNT_MSB = 17;
   localparam int EVT_W = 2;
   localparam int EVT_RISE_BIT = 0;
   localparam int EVT_DONE_BIT = 1;
   // reset values
   localparam logic ENABLE_RST = 1'b0;
   localparam logic [CNT_W-1:0] CNT_RST = 18'h00000;
   localparam logic [EVT_W-1:0] EVT_RST = 2'h0;
   localparam logic [DATA_W-1:0] RDATA_RST = 32'h00000000;
endpackage

// file: core/cip_top.sv
// Purpose: merges level interrupt sources into one paced line to the cpu
// Assumes: sources are level, synchronous to REF_CLK_IN (50 MHz)
// Notes: service software is expected to drop and re-raise the enable
//
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/1ns
module cip_top (
   // clock and reset
   input wire logic REF_CLK_IN,
   input wire logic RST_IN,
   // register port
   input wire logic [cip_pkg::ADDR_W-1:0] REG_ADDR_IN,
   input wire logic [cip_pkg::DATA_W-1:0] REG_WDATA_IN,
   input wire logic REG_WR_IN,
   input wire logic REG_RD_IN,
   output logic [cip_pkg::DATA_W-1:0] REG_RDATA_OUT,
   // interrupt sources and outputs
   input wire logic [cip_pkg::SRC_W-1:0] SRC_IRQ_IN,
   output logic COMBINED_IRQ_OUT,
   output logic EVT_IRQ_OUT
);
   import cip_pkg::*;

   logic combined_irq_enable_r;
   logic combined_irq_enable_nxt;
   logic [CNT_W-1:0] interrupt_pacing_count_r;
   logic [CNT_W-1:0] interrupt_pacing_count_nxt;
   logic [EVT_W-1:0] evt_status_r;
   logic [EVT_W-1:0] evt_status_nxt;
   logic [EVT_W-1:0] evt_mask_r;
   logic [EVT_W-1:0] evt_mask_nxt;
   logic combined_irq_r;
   logic combined_irq_nxt;
   logic [DATA_W-1:0] rdata_r;
   logic [DATA_W-1:0] rdata_nxt;
   logic wr_ctl;
   logic wr_cnt;
   logic timer_load;
   logic [CNT_W-1:0] timer_count;
   logic timer_zero;
   logic [EVT_W-1:0] evt_set;

   // write decode
   assign wr_ctl = REG_WR_IN && (REG_ADDR_IN == CTL_OFS);
   assign wr_cnt = REG_WR_IN && (REG_ADDR_IN == CNT_OFS);

   // reload only on a 0 to 1 change of the enable; rewriting 1 keeps the count running
   assign timer_load = wr_ctl && REG_WDATA_IN[ENABLE_BIT] && !combined_irq_enable_r;

   // pacing timer
   cip_pace_counter #(
      .W(CNT_W)
   ) u_timer (
      .clk_in(REF_CLK_IN),
      .rst_in(RST_IN),
      .load_in(timer_load),
      .load_value_in(interrupt_pacing_count_r),
      .count_out(timer_count),
      .zero_out(timer_zero)
   );

   // software registers: enable, pacing count, event mask
   always_comb begin
      combined_irq_enable_nxt = combined_irq_enable_r;
      interrupt_pacing_count_nxt = interrupt_pacing_count_r;
      evt_mask_nxt = evt_mask_r;
      if (wr_ctl) begin
         combined_irq_enable_nxt = REG_WDATA_IN[ENABLE_BIT];
      end
      if (wr_cnt) begin
         interrupt_pacing_count_nxt = REG_WDATA_IN[CNT_MSB:0];
      end
      if (REG_WR_IN && (REG_ADDR_IN == MASK_OFS)) begin
         evt_mask_nxt = REG_WDATA_IN[EVT_W-1:0];
      end
   end

   // combined line is registered so the cpu sees a clean edge
   always_comb begin
      combined_irq_nxt = (|SRC_IRQ_IN) && combined_irq_enable_r && timer_zero;
   end

   // sticky events; a new event beats a write-one-to-clear in the same cycle
   always_comb begin
      evt_set = EVT_RST;
      evt_set[EVT_RISE_BIT] = combined_irq_nxt && !combined_irq_r;
      evt_set[EVT_DONE_BIT] = !timer_load && (timer_count == CNT_W'(1));
      evt_status_nxt = evt_status_r;
      if (REG_WR_IN && (REG_ADDR_IN == STAT_OFS)) begin
         evt_status_nxt = evt_status_r & ~REG_WDATA_IN[EVT_W-1:0];
      end
      evt_status_nxt = evt_status_nxt | evt_set;
   end

   // read mux; data stand only in the cycle after the strobe, unmapped reads give 0
   always_comb begin
      rdata_nxt = RDATA_RST;
      if (REG_RD_IN) begin
         unique case (REG_ADDR_IN)
            CTL_OFS: rdata_nxt[ENABLE_BIT] = combined_irq_enable_r;
            CNT_OFS: rdata_nxt[CNT_MSB:0] = interrupt_pacing_count_r;
            TIMER_OFS: rdata_nxt[CNT_MSB:0] = timer_count;
            STAT_OFS: rdata_nxt[EVT_W-1:0] = evt_status_r;
            MASK_OFS: rdata_nxt[EVT_W-1:0] = evt_mask_r;
            default: rdata_nxt = RDATA_RST;
         endcase
      end
   end

   // state registers
   always_ff @(posedge REF_CLK_IN) begin
      if (RST_IN) begin
         combined_irq_enable_r <= ENABLE_RST;
         interrupt_pacing_count_r <= CNT_RST;
         evt_status_r <= EVT_RST;
         evt_mask_r <= EVT_RST;
         combined_irq_r <= 1'b0;
         rdata_r <= RDATA_RST;
      end else begin
         combined_irq_enable_r <= combined_irq_enable_nxt;
         interrupt_pacing_count_r <= interrupt_pacing_count_nxt;
         evt_status_r <= evt_status_nxt;
         evt_mask_r <= evt_mask_nxt;
         combined_irq_r <= combined_irq_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // outputs
   assign REG_RDATA_OUT = rdata_r;
   assign COMBINED_IRQ_OUT = combined_irq_r;
   assign EVT_IRQ_OUT = |(evt_status_r & evt_mask_r);

   // a reset leaves no pacing in force
   a_reset_no_pace: assert property (@(posedge REF_CLK_IN)
      $past(RST_IN) |-> (interrupt_pacing_count_r == CNT_RST) && timer_zero)
      else $error("pacing count not zero after reset");

   // count readback carries only the low field
   a_count_readback: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
      (wr_cnt ##1 (REG_RD_IN && REG_ADDR_IN == CNT_OFS && !REG_WR_IN))
      |=> (REG_RDATA_OUT == {14'h0000, $past(REG_WDATA_IN[CNT_MSB:0], 2)}))
      else $error("pacing count readback wrong");

   // rising enable loads the programmed count
   a_load_on_rise: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
      timer_load |=> (timer_count == $past(interrupt_pacing_count_r)))
      else $error("timer not loaded on enable rise");

   // rewriting a set enable does not reload
   a_no_reload_set: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
      (wr_ctl && combined_irq_enable_r && !timer_zero)
      |=> (timer_count == $past(timer_count) - CNT_W'(1)))
      else $error("timer reloaded while enable already set");

   // counts down by one per clock
   a_count_down: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
      (!timer_load && !timer_zero) |=> (timer_count == $past(timer_count) - CNT_W'(1)))
      else $error("timer did not decrement");

   // stays at zero until the next load
   a_stop_at_zero: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
      (!timer_load && timer_zero) |=> timer_zero)
      else $error("timer left zero without a load");

   // non-zero timer blocks the line
   a_block_pacing: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
      !timer_zero |=> !COMBINED_IRQ_OUT)
      else $error("combined irq high while timer running");

   // line follows pending sources when allowed
   a_assert_when_ready: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
      ((|SRC_IRQ_IN) && combined_irq_enable_r && timer_zero) |=> COMBINED_IRQ_OUT)
      else $error("combined irq missing");

   // disabled line stays low
   a_disable_low: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
      !combined_irq_enable_r |=> !COMBINED_IRQ_OUT)
      else $error("combined irq high while disabled");

   // reset leaves the line, the enable and the read port idle
   a_reset_outputs: assert property (@(posedge REF_CLK_IN)
      $past(RST_IN) |-> !combined_irq_enable_r && !COMBINED_IRQ_OUT && !EVT_IRQ_OUT
         && (REG_RDATA_OUT == RDATA_RST))
      else $error("outputs not idle after reset");

   // the rise event is latched at the edge the line goes high
   a_rise_event: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
      $rose(COMBINED_IRQ_OUT) |-> evt_status_r[EVT_RISE_BIT])
      else $error("rise event not latched");

   // timer reaching zero on its own latches done, even against a clear
   a_done_event: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
      (!timer_load && (timer_count == CNT_W'(1))) |=> evt_status_r[EVT_DONE_BIT])
      else $error("pacing done event lost");

   // writing a one clears a status bit unless its event fires again
   a_status_clear: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
      (REG_WR_IN && (REG_ADDR_IN == STAT_OFS) && REG_WDATA_IN[EVT_RISE_BIT]
         && !evt_set[EVT_RISE_BIT]) |=> !evt_status_r[EVT_RISE_BIT])
      else $error("status bit not cleared");

   // read data stand for one cycle only, zero otherwise
   a_read_idle_zero: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
      !REG_RD_IN |=> (REG_RDATA_OUT == RDATA_RST))
      else $error("read data outside the answer cycle");

   // reserved upper bits of the count read as zero
   a_reserved_zero: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
      (REG_RD_IN && (REG_ADDR_IN == CNT_OFS)) |=> (REG_RDATA_OUT[DATA_W-1:CNT_W] == '0))
      else $error("reserved count bits not zero");

   // line drops one cycle after the last source goes quiet
   a_irq_falls: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
      !(|SRC_IRQ_IN) |=> !COMBINED_IRQ_OUT)
      else $error("combined irq high with no source");

   // a reload with a non-zero count keeps the line low two cycles on
   a_load_blocks: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
      (timer_load && (interrupt_pacing_count_r != '0)) |-> ##2 !COMBINED_IRQ_OUT)
      else $error("combined irq high right after a reload");
endmodule

// file: dv/cip_cpu_model.sv
// Purpose: cpu interrupt controller on the far side of the paced line
// Assumes: edge sensitive, sampled on the peripheral clock
// Notes: a level left high counts once, so service code must re-arm
`timescale 1ns/1ns
module cip_cpu_model (
   // clock, reset and line
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic irq_in,
   // edges taken
   output int edges_out
);
   logic last_r;
   // count each low to high edge as one request
   always @(posedge clk_in) begin
      last_r <= rst_in ? 1'b0 : irq_in;
      if (rst_in) edges_out <= 0;
      else if (irq_in && !last_r) edges_out <= edges_out + 1;
   end
endmodule

// file: dv/test_combined_interrupt_pacer.sv
// Purpose: self-checking bench of the paced combined interrupt
// Assumes: timer counts every clock, offsets from cip_pkg
// Notes: pacing counts kept small so the run stays short
`timescale 1ns/1ns
module test_combined_interrupt_pacer;
   import cip_pkg::*;
   logic clk, rst, wr, rd, irq, evt, m_en, m_irq, m_load;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata, rdata, m_rd;
   logic [SRC_W-1:0] src;
   logic [31:0] seed;
   logic [CNT_W-1:0] m_cnt, m_tmr;
   logic [1:0] m_st, m_mk, m_set;
   int bad_count, checks_done, edges, m_edges;
   cip_top cip_top_inst (.REF_CLK_IN(clk), .RST_IN(rst), .REG_ADDR_IN(addr),
      .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata),
      .SRC_IRQ_IN(src), .COMBINED_IRQ_OUT(irq), .EVT_IRQ_OUT(evt));
   cip_cpu_model cip_cpu_model_inst (.clk_in(clk), .rst_in(rst), .irq_in(irq),
      .edges_out(edges));
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // one idle cycle after each strobe keeps a single driver per step
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd_reg(input logic [7:0] a);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
   endtask
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // sources come and go at random, sometimes all quiet
   always @(posedge clk) begin
      seed = lfsr(seed);
      src <= seed[31] ? seed[SRC_W-1:0] : '0;
   end
   // reference model, sampling the same edges as the design
   always @(posedge clk) begin
      m_load = wr && addr == CTL_OFS && wdata[0] && !m_en;
      m_set = {!m_load && m_tmr == 1, m_en && m_tmr == 0 && |src && !m_irq};
      if (rst) begin
         {m_en, m_irq, m_cnt, m_tmr, m_st, m_mk, m_rd} <= '0;
         m_edges <= 0;
      end else begin
         m_irq <= m_en && m_tmr == 0 && |src;
         m_tmr <= m_load ? m_cnt : m_tmr - (m_tmr != 0);
         if (wr && addr == CTL_OFS) m_en <= wdata[0];
         if (wr && addr == CNT_OFS) m_cnt <= wdata[CNT_MSB:0];
         if (wr && addr == MASK_OFS) m_mk <= wdata[1:0];
         m_st <= (m_st & ~((wr && addr == STAT_OFS) ? wdata[1:0] : 2'h0)) | m_set;
         if (m_set[0]) m_edges <= m_edges + 1;
         m_rd <= !rd ? 32'h0 : addr == CTL_OFS ? {31'h0, m_en} :
            addr == CNT_OFS ? 32'(m_cnt) : addr == TIMER_OFS ? 32'(m_tmr) :
            addr == STAT_OFS ? 32'(m_st) : addr == MASK_OFS ? 32'(m_mk) : 32'h0;
      end
   end
   // compare every settled cycle, reset included
   always @(negedge clk) begin
      chk(irq, m_irq);
      chk(evt, |(m_st & m_mk));
      chk(rdata, m_rd);
   end
   // watchdog far beyond the fewer than two thousand cycles needed
   initial begin
      #1000000;
      bad_count++;
      report_and_stop();
   end
   initial begin
      {wr, rd, addr, wdata, src} = '0;
      rst = 1'b1;
      seed = 32'hF58FFF34;
      bad_count = 0;
      checks_done = 0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      rd_reg(CNT_OFS);
      rd_reg(CTL_OFS);
      // write then read with no gap, as the port allows
      addr <= CNT_OFS;
      wdata <= 32'hFFFFFFFF;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
      wr_reg(MASK_OFS, 32'h3);
      wr_reg(CNT_OFS, 32'h20);
      wr_reg(CTL_OFS, 32'h1);
      rd_reg(TIMER_OFS);
      repeat (12) @(posedge clk);
      // rewrite of a set enable while the timer still runs: no reload
      wr_reg(CTL_OFS, 32'h1);
      rd_reg(TIMER_OFS);
      // service loop: drop enable, clear, new count, re-arm
      for (int i = 0; i < 24; i++) begin
         wr_reg(CTL_OFS, 32'h0);
         wr_reg(STAT_OFS, {30'h0, seed[1:0]});
         wr_reg(CNT_OFS, {26'h0, seed[7:2]});
         wr_reg(CTL_OFS, 32'h1);
         repeat (seed[13:8]) @(posedge clk);
         rd_reg(seed[0] ? 8'h20 : TIMER_OFS);
      end
      // line quiet before the edge counts are compared
      wr_reg(CTL_OFS, 32'h0);
      rd_reg(8'h00);
      @(negedge clk);
      chk(edges, m_edges);
      @(posedge clk);
      // mid-run reset must bring the written count back to zero
      wr_reg(MASK_OFS, 32'h0);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rd_reg(CNT_OFS);
      report_and_stop();
   end
endmodule
